// File: logic/cacu_alarm_cmd.v
/*
 Channel alarm command unit: parses addressed ASCII alarm requests,
 keeps per-channel low and high alarms, drives the alarm output ports
 and answers the host. Assumes one byte per rx_valid_i cycle, eight
 readings in signed hundredths of the selected scale, and a host
 that waits for each answer before the next request.
*/
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "cacu_defs.vh"
module cacu_alarm_cmd (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  input wire rx_err_i,
  output wire [7:0] tx_data_o,
  output wire tx_valid_o,
  input wire tx_ready_i,
  input wire [143:0] reading_i,
  input wire [4:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [31:0] reg_rdata_o,
  output wire [7:0] do_o,
  output wire scale_o,
  output wire irq_o
);
  localparam S_RX = 2'b01;
  localparam S_TX = 2'b10;

  function [4:0] hexv;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39) hexv = {1'b1, c[3:0]};
      else if (c >= 8'h41 && c <= 8'h46) hexv = {1'b1, c[3:0] + 4'h9};
      else hexv = 5'h00;
    end
  endfunction

  function [7:0] hexc;
    input [3:0] n;
    begin
      hexc = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
    end
  endfunction

  function isdig;
    input [7:0] c;
    begin
      isdig = c >= 8'h30 && c <= 8'h39;
    end
  endfunction

  function signed [17:0] tobin;
    input [20:0] l;
    reg [17:0] m;
    begin
      m = {14'h0, l[19:16]} * 18'h02710 + {14'h0, l[15:12]} * 18'h003E8
        + {14'h0, l[11:8]} * 18'h00064 + {14'h0, l[7:4]} * 18'h0000A
        + {14'h0, l[3:0]};
      tobin = l[20] ? -m : m;
    end
  endfunction

  reg [7:0] buf_q [0:19];
  reg [7:0] resp_q [0:14];
  reg [4:0] len_q;
  reg bad_q;
  reg [1:0] state_q;
  reg [3:0] idx_q;
  reg [3:0] rlen_q;
  reg [7:0] tx_data_q;
  reg tx_valid_q;
  reg [7:0] addr_q;
  reg scale_q;
  reg [3:0] stat_q;
  reg [3:0] mask_q;
  reg [7:0] dout_q;
  reg [7:0] do_q;
  reg [31:0] rdata_q;
  reg irq_q;
  reg [20:0] lo_lim_q [0:7];
  reg [20:0] hi_lim_q [0:7];
  reg [1:0] lo_type_q [0:7];
  reg [1:0] hi_type_q [0:7];
  reg [2:0] lo_port_q [0:7];
  reg [2:0] hi_port_q [0:7];
  reg [7:0] lo_act_q;
  reg [7:0] hi_act_q;
  reg [7:0] lo_act_d;
  reg [7:0] hi_act_d;
  reg [7:0] assigned;
  reg [7:0] port_on;
  reg [7:0] hi_mask;
  reg [7:0] lo_mask;
  reg [1:0] dec_ans;
  reg [2:0] dec_cmd;
  reg [2:0] dec_ch;
  reg [2:0] dec_port;
  reg [1:0] dec_type;
  reg [20:0] dec_lim;
  reg [4:0] base;
  reg [4:0] a_hi;
  reg [4:0] a_lo;
  reg [4:0] ck_a;
  reg [4:0] ck_b;
  reg [15:0] code;
  reg [7:0] idxc;
  reg [20:0] rd_lim;
  reg [1:0] rd_type;
  reg [2:0] rd_port;
  reg [3:0] rlen_d;
  reg [3:0] ev;
  reg signed [17:0] rd;
  integer i;
  integer p;
  integer k;

  wire go = state_q == S_RX && rx_valid_i && rx_data_i == `CACU_CH_CR;
  wire ans_ok = go && dec_ans == 2'b01;
  wire ans_any = go && dec_ans != 2'b00;
  wire is_set = dec_cmd == 3'd0 || dec_cmd == 3'd1;

  // Frame decode; dec_ans 00 silent, 01 accepted, 10 invalid
  always @* begin
    dec_ans = 2'b00;
    dec_cmd = 3'd7;
    dec_ch = 3'd0;
    dec_port = 3'd0;
    dec_type = `CACU_TYPE_OFF;
    a_hi = hexv(buf_q[1]);
    a_lo = hexv(buf_q[2]);
    code = {buf_q[3], buf_q[4]};
    case (code)
      `CACU_SET_LOW_LIMIT_CODE: dec_cmd = 3'd0;
      `CACU_SET_HIGH_LIMIT_CODE: dec_cmd = 3'd1;
      `CACU_READ_ACTIVE_ALARMS_CODE: dec_cmd = 3'd2;
      `CACU_READ_HIGH_SETTINGS_CODE: dec_cmd = 3'd3;
      `CACU_READ_LOW_SETTINGS_CODE: dec_cmd = 3'd4;
      `CACU_CLEAR_LOW_LATCH_CODE: dec_cmd = 3'd5;
      `CACU_CLEAR_HIGH_LATCH_CODE: dec_cmd = 3'd6;
      default: dec_cmd = 3'd7;
    endcase
    base = (dec_cmd < 3'd2) ? `CACU_SET_LEN : `CACU_SHORT_LEN;
    ck_a = hexv(buf_q[base]);
    ck_b = hexv(buf_q[base + 5'h01]);
    dec_lim = {buf_q[5] == `CACU_CH_MINUS, buf_q[6][3:0], buf_q[7][3:0],
               buf_q[8][3:0], buf_q[10][3:0], buf_q[11][3:0]};
    idxc = (dec_cmd < 3'd2) ? buf_q[13] : buf_q[6];
    dec_ch = idxc[2:0];
    dec_port = (dec_cmd < 3'd2) ? buf_q[16][2:0] : buf_q[6][2:0];
    if (!bad_q && buf_q[0] == `CACU_CH_LEAD && len_q >= 5'h05 &&
        a_hi[4] && a_lo[4] && {a_hi[3:0], a_lo[3:0]} == addr_q) begin
      if (dec_cmd == 3'd7) begin
        dec_ans = 2'b10;
      end else if (len_q == base ||
                   (len_q == base + 5'h02 && ck_a[4] && ck_b[4])) begin
        if (dec_cmd < 3'd2) begin
          if ((buf_q[5] == `CACU_CH_PLUS || buf_q[5] == `CACU_CH_MINUS) &&
              isdig(buf_q[6]) && isdig(buf_q[7]) && isdig(buf_q[8]) &&
              buf_q[9] == `CACU_CH_POINT && isdig(buf_q[10]) &&
              isdig(buf_q[11]) && buf_q[12] == `CACU_CH_C &&
              isdig(buf_q[13]) && buf_q[15] == `CACU_CH_O &&
              isdig(buf_q[16]) &&
              (buf_q[14] == `CACU_CH_M || buf_q[14] == `CACU_CH_L)) begin
            dec_type = (buf_q[14] == `CACU_CH_M) ? `CACU_TYPE_MOM :
                       `CACU_TYPE_LATCH;
            dec_ans = (buf_q[13][3:0] > 4'h7 || buf_q[16][3:0] > 4'h7) ?
                      2'b10 : 2'b01;
          end
        end else if (isdig(buf_q[6]) &&
                     buf_q[5] == ((dec_cmd == 3'd2) ? `CACU_CH_O :
                                  `CACU_CH_C)) begin
          dec_ans = (buf_q[6][3:0] > 4'h7) ? 2'b10 : 2'b01;
        end
      end
    end
  end

  // Alarm evaluation and port combining
  always @* begin
    assigned = 8'h00;
    port_on = 8'h00;
    hi_mask = 8'h00;
    lo_mask = 8'h00;
    lo_act_d = 8'h00;
    hi_act_d = 8'h00;
    rd = 18'h00000;
    for (i = 0; i < 8; i = i + 1) begin
      rd = reading_i[i * 18 +: 18];
      lo_act_d[i] = lo_type_q[i] != `CACU_TYPE_OFF && (rd < tobin(lo_lim_q[i])
        || (lo_type_q[i] == `CACU_TYPE_LATCH && lo_act_q[i] &&
            !(ans_ok && dec_cmd == 3'd5 && dec_ch == i[2:0])));
      hi_act_d[i] = hi_type_q[i] != `CACU_TYPE_OFF && (rd > tobin(hi_lim_q[i])
        || (hi_type_q[i] == `CACU_TYPE_LATCH && hi_act_q[i] &&
            !(ans_ok && dec_cmd == 3'd6 && dec_ch == i[2:0])));
      for (p = 0; p < 8; p = p + 1) begin
        if (lo_type_q[i] != `CACU_TYPE_OFF && lo_port_q[i] == p[2:0]) begin
          assigned[p] = 1'b1;
          port_on[p] = port_on[p] | lo_act_q[i];
        end
        if (hi_type_q[i] != `CACU_TYPE_OFF && hi_port_q[i] == p[2:0]) begin
          assigned[p] = 1'b1;
          port_on[p] = port_on[p] | hi_act_q[i];
        end
      end
      hi_mask[i] = hi_act_q[i] && hi_type_q[i] != `CACU_TYPE_OFF &&
                   hi_port_q[i] == dec_port;
      lo_mask[i] = lo_act_q[i] && lo_type_q[i] != `CACU_TYPE_OFF &&
                   lo_port_q[i] == dec_port;
    end
  end

  always @* begin
    rd_lim = (dec_cmd == 3'd3) ? hi_lim_q[dec_ch] : lo_lim_q[dec_ch];
    rd_type = (dec_cmd == 3'd3) ? hi_type_q[dec_ch] : lo_type_q[dec_ch];
    rd_port = (dec_cmd == 3'd3) ? hi_port_q[dec_ch] : lo_port_q[dec_ch];
    if (dec_ans == 2'b01 && dec_cmd == 3'd2) rlen_d = 4'h7;
    else if (dec_ans == 2'b01 && (dec_cmd == 3'd3 || dec_cmd == 3'd4))
      rlen_d = 4'hD;
    else rlen_d = 4'h3;
    ev = 4'h0;
    ev[`CACU_EV_ALARM] = |((lo_act_d & ~lo_act_q) | (hi_act_d & ~hi_act_q));
    ev[`CACU_EV_OK] = ans_ok;
    ev[`CACU_EV_BAD] = go && dec_ans == 2'b10;
    ev[`CACU_EV_DROP] = go && dec_ans == 2'b00;
  end

  // Frame and answer storage, data only
  always @(posedge core_clk_i) begin
    if (state_q == S_RX && rx_valid_i && rx_data_i != `CACU_CH_CR &&
        len_q < `CACU_BUF_DEPTH) begin
      if (rx_data_i == `CACU_CH_LEAD) buf_q[0] <= rx_data_i;
      else buf_q[len_q] <= rx_data_i;
    end
    if (ans_any) begin
      resp_q[0] <= (dec_ans == 2'b01) ? `CACU_CH_OK : `CACU_CH_BAD;
      resp_q[1] <= hexc(addr_q[7:4]);
      resp_q[2] <= hexc(addr_q[3:0]);
      resp_q[3] <= rd_lim[20] ? `CACU_CH_MINUS : `CACU_CH_PLUS;
      resp_q[4] <= {4'h3, rd_lim[19:16]};
      resp_q[5] <= {4'h3, rd_lim[15:12]};
      resp_q[6] <= {4'h3, rd_lim[11:8]};
      resp_q[7] <= `CACU_CH_POINT;
      resp_q[8] <= {4'h3, rd_lim[7:4]};
      resp_q[9] <= {4'h3, rd_lim[3:0]};
      resp_q[10] <= {6'h0C, rd_type};
      resp_q[11] <= `CACU_CH_O;
      resp_q[12] <= {5'h06, rd_port};
      if (dec_cmd == 3'd2) begin
        resp_q[3] <= hexc(hi_mask[7:4]);
        resp_q[4] <= hexc(hi_mask[3:0]);
        resp_q[5] <= hexc(lo_mask[7:4]);
        resp_q[6] <= hexc(lo_mask[3:0]);
      end
      resp_q[rlen_d] <= `CACU_CH_CR;
    end
  end

  // Receive, answer sequencing and alarm state
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= S_RX;
      len_q <= 5'h00;
      bad_q <= 1'b0;
      idx_q <= 4'h0;
      rlen_q <= 4'h0;
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
      lo_act_q <= 8'h00;
      hi_act_q <= 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        lo_lim_q[k] <= 21'h0;
        hi_lim_q[k] <= 21'h0;
        lo_type_q[k] <= `CACU_TYPE_OFF;
        hi_type_q[k] <= `CACU_TYPE_OFF;
        lo_port_q[k] <= 3'h0;
        hi_port_q[k] <= 3'h0;
      end
    end else begin
      lo_act_q <= lo_act_d;
      hi_act_q <= hi_act_d;
      if (ans_ok && is_set) begin
        if (dec_cmd == 3'd0) begin
          lo_lim_q[dec_ch] <= dec_lim;
          lo_type_q[dec_ch] <= dec_type;
          lo_port_q[dec_ch] <= dec_port;
          lo_act_q[dec_ch] <= 1'b0;
        end else begin
          hi_lim_q[dec_ch] <= dec_lim;
          hi_type_q[dec_ch] <= dec_type;
          hi_port_q[dec_ch] <= dec_port;
          hi_act_q[dec_ch] <= 1'b0;
        end
      end
      case (state_q)
        S_RX: begin
          if (rx_valid_i) begin
            if (rx_data_i == `CACU_CH_CR) begin
              len_q <= 5'h00;
              bad_q <= 1'b0;
              if (ans_any) begin
                state_q <= S_TX;
                idx_q <= 4'h0;
                rlen_q <= rlen_d;
              end
            end else if (rx_data_i == `CACU_CH_LEAD) begin
              len_q <= 5'h01;
              bad_q <= rx_err_i;
            end else if (len_q < `CACU_BUF_DEPTH) begin
              len_q <= len_q + 5'h01;
              bad_q <= bad_q | rx_err_i;
            end else begin
              bad_q <= 1'b1;
            end
          end
        end
        S_TX: begin
          if (!tx_valid_q || tx_ready_i) begin
            if (idx_q <= rlen_q) begin
              tx_data_q <= resp_q[idx_q];
              tx_valid_q <= 1'b1;
              idx_q <= idx_q + 4'h1;
            end else begin
              tx_valid_q <= 1'b0;
              state_q <= S_RX;
            end
          end
        end
        default: state_q <= S_RX;
      endcase
    end
  end

  // Register port, interrupt and output ports
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_q <= `CACU_ADDR_RST;
      scale_q <= 1'b0;
      stat_q <= 4'h0;
      mask_q <= 4'h0;
      dout_q <= 8'h00;
      do_q <= 8'h00;
      rdata_q <= 32'h00000000;
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((reg_wr_i && reg_addr_i == `CACU_REG_STAT) ?
                reg_wdata_i[3:0] : 4'h0)) | ev;
      irq_q <= |(stat_q & mask_q);
      do_q <= (assigned & port_on) | (~assigned & dout_q);
      if (reg_wr_i) begin
        case (reg_addr_i)
          `CACU_REG_ADDR: addr_q <= reg_wdata_i[7:0];
          `CACU_REG_CTRL: scale_q <= reg_wdata_i[`CACU_CTRL_SCALE_BIT];
          `CACU_REG_MASK: mask_q <= reg_wdata_i[3:0];
          `CACU_REG_DOUT: dout_q <= reg_wdata_i[7:0];
          default: addr_q <= addr_q;
        endcase
      end
      rdata_q <= 32'h00000000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `CACU_REG_ADDR: rdata_q <= {24'h000000, addr_q};
          `CACU_REG_CTRL: rdata_q <= {31'h00000000, scale_q};
          `CACU_REG_STAT: rdata_q <= {28'h0000000, stat_q};
          `CACU_REG_MASK: rdata_q <= {28'h0000000, mask_q};
          `CACU_REG_DOUT: rdata_q <= {24'h000000, do_q};
          `CACU_REG_ACT: rdata_q <= {16'h0000, hi_act_q, lo_act_q};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign tx_data_o = tx_data_q;
  assign tx_valid_o = tx_valid_q;
  assign reg_rdata_o = rdata_q;
  assign do_o = do_q;
  assign scale_o = scale_q;
  assign irq_o = irq_q;
endmodule

// File: logic/cacu_defs.vh
/*
 Constants of the channel alarm command unit: command codes, characters,
 register offsets, field positions and reset values.
 Assumes byte-wide ASCII frames and a 5-bit register byte address.
*/
// Function
// - Set-low frame: address, code, limit, channel, type, port
// - Limit is sign, three digits, point, two
// - Type letter M momentary, L latched
// - Reported type: 0 off, 1 momentary, 2 latched
// - Accepted gives ! address; invalid gives ? address
// - Malformed, comm error, foreign address: stay silent
// - Port on while any mapped alarm active
// - Active read replies high mask, low mask
// - Mask bit set means active mapped alarm
// - Bad port or invalid request gives ? address
// - High read: limit, type digit, O port
// - Low read: same layout for low alarm
// - Limits use selected scale, Celsius after reset
// - Clear requests reset latched low or high
// - Direct writes ignored on alarm-assigned ports
`ifndef CACU_DEFS_VH
`define CACU_DEFS_VH
`define CACU_CH_LEAD 8'h40
`define CACU_CH_OK 8'h21
`define CACU_CH_BAD 8'h3F
`define CACU_CH_CR 8'h0D
`define CACU_CH_PLUS 8'h2B
`define CACU_CH_MINUS 8'h2D
`define CACU_CH_POINT 8'h2E
`define CACU_CH_C 8'h43
`define CACU_CH_O 8'h4F
`define CACU_CH_M 8'h4D
`define CACU_CH_L 8'h4C
`define CACU_CH_ZERO 8'h30
`define CACU_SET_LOW_LIMIT_CODE 16'h4C4F
`define CACU_SET_HIGH_LIMIT_CODE 16'h4849
`define CACU_READ_ACTIVE_ALARMS_CODE 16'h5241
`define CACU_READ_HIGH_SETTINGS_CODE 16'h5248
`define CACU_READ_LOW_SETTINGS_CODE 16'h524C
`define CACU_CLEAR_LOW_LATCH_CODE 16'h434C
`define CACU_CLEAR_HIGH_LATCH_CODE 16'h4348
`define CACU_SET_LEN 5'h11
`define CACU_SHORT_LEN 5'h07
`define CACU_BUF_DEPTH 5'h14
`define CACU_TYPE_OFF 2'h0
`define CACU_TYPE_MOM 2'h1
`define CACU_TYPE_LATCH 2'h2
`define CACU_REG_ADDR 5'h00
`define CACU_REG_CTRL 5'h04
`define CACU_REG_STAT 5'h08
`define CACU_REG_MASK 5'h0C
`define CACU_REG_DOUT 5'h10
`define CACU_REG_ACT 5'h14
`define CACU_ADDR_RST 8'h01
`define CACU_CTRL_SCALE_BIT 0
`define CACU_EV_ALARM 0
`define CACU_EV_OK 1
`define CACU_EV_BAD 2
`define CACU_EV_DROP 3
`endif

// File: testbench/cacu_alarm_cmd_checker.sv
/*
 Checker for the alarm command unit: answer framing, register reads
 and scale control. Assumes the host waits for each answer.
*/
`timescale 1ns/100ps
`include "cacu_defs.vh"
module cacu_alarm_cmd_checker (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  input wire [7:0] tx_data_o,
  input wire tx_valid_o,
  input wire tx_ready_i,
  input wire [4:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire [7:0] do_o,
  input wire scale_o,
  input wire irq_o
);
  logic [3:0] idx_q;
  logic lim_q;
  logic [7:0] addr_q;
  wire cr_w = rx_valid_i && rx_data_i == `CACU_CH_CR;
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction
  // Byte position in the answer, own address
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_q <= 4'h0;
      lim_q <= 1'b0;
      addr_q <= `CACU_ADDR_RST;
    end else begin
      if (!tx_valid_o) begin
        idx_q <= 4'h0;
        lim_q <= 1'b0;
      end else if (tx_ready_i) begin
        idx_q <= idx_q + 4'h1;
        if (idx_q == 4'h3) begin
          lim_q <= tx_data_o == `CACU_CH_PLUS || tx_data_o == `CACU_CH_MINUS;
        end
      end
      if (reg_wr_i && reg_addr_i == `CACU_REG_ADDR) begin
        addr_q <= reg_wdata_i[7:0];
      end
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_LEAD: assert property (tx_valid_o && idx_q == 4'h0 |->
    tx_data_o == `CACU_CH_OK || tx_data_o == `CACU_CH_BAD)
    else $error("answer lead byte wrong");
  AST_ADDR_HI: assert property (tx_valid_o && idx_q == 4'h1 |->
    tx_data_o == hexc(addr_q[7:4])) else $error("answer address high");
  AST_ADDR_LO: assert property (tx_valid_o && idx_q == 4'h2 |->
    tx_data_o == hexc(addr_q[3:0])) else $error("answer address low");
  AST_TAIL: assert property ($fell(tx_valid_o) |->
    $past(tx_data_o) == `CACU_CH_CR) else $error("answer not ended by CR");
  AST_CAUSE: assert property ($rose(tx_valid_o) |->
    $past(cr_w, 2) || $past(cr_w, 3)) else $error("answer without request");
  AST_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("answer byte dropped");
  AST_POINT: assert property (tx_valid_o && idx_q == 4'h7 && lim_q |->
    tx_data_o == `CACU_CH_POINT) else $error("limit point missing");
  AST_SCALE: assert property (reg_wr_i &&
    reg_addr_i == `CACU_REG_CTRL |=> scale_o == $past(reg_wdata_i[0]))
    else $error("scale not taken");
  AST_ADDR_RD: assert property (reg_rd_i &&
    reg_addr_i == `CACU_REG_ADDR |=> reg_rdata_o == {24'h0, addr_q})
    else $error("address read wrong");
  cover property (tx_valid_o && !tx_ready_i);
  cover property ($rose(irq_o));
  cover property ($rose(do_o[3]));
endmodule
bind cacu_alarm_cmd cacu_alarm_cmd_checker u_chk (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
  .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .do_o(do_o),
  .scale_o(scale_o), .irq_o(irq_o));

// File: testbench/cacu_host_model.sv
/*
 Host on the command link: sends framed requests byte by byte and
 collects answers, stalling the sink at random while slow is set.
*/
`timescale 1ns/100ps
module cacu_host_model (
  input wire core_clk_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_err_o,
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  output logic tx_ready_o
);
  logic [7:0] rxq[$];
  logic [31:0] pat_q = 32'h0000A5C3;
  bit slow = 1'b0;
  initial begin
    rx_data_o = 8'h5A;
    rx_valid_o = 1'b0;
    rx_err_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // Sink, stalls on a pattern when slow
  always @(posedge core_clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      rxq.push_back(tx_data_i);
    end
    pat_q <= {pat_q[30:0], pat_q[31] ^ pat_q[21] ^ pat_q[1] ^ pat_q[0]};
    tx_ready_o <= !slow || pat_q[0];
  end
  task automatic send(input string s, input bit err);
    repeat (2) @(posedge core_clk_i);
    foreach (s[i]) begin
      rx_data_o <= s[i];
      rx_valid_o <= 1'b1;
      rx_err_o <= err && i == 1;
      @(posedge core_clk_i);
    end
    rx_data_o <= 8'h0D;
    rx_err_o <= 1'b0;
    @(posedge core_clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= 8'hF2;
  endtask
  task automatic get(output string r);
    int n;
    logic [7:0] b;
    r = "";
    n = 0;
    while (n < 80 && !(rxq.size() > 0 && rxq[$] == 8'h0D)) begin
      @(posedge core_clk_i);
      n++;
    end
    while (rxq.size() > 0) begin
      b = rxq.pop_front();
      if (b != 8'h0D) r = $sformatf("%s%c", r, b);
    end
  endtask
endmodule

// File: testbench/test_channel_alarm_command_unit.sv
/*
 Bench for the alarm command unit: random and corner requests through
 the host model, register, interrupt and alarm port checks.
*/
`timescale 1ns/100ps
`include "cacu_defs.vh"
module test_channel_alarm_command_unit;
  logic core_clk_i;
  logic rst_n_i;
  logic [4:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [143:0] reading;
  wire [7:0] rx_data, tx_data, do_o;
  wire rx_valid, rx_err, tx_valid, tx_ready, scale_o, irq_o;
  wire [31:0] reg_rdata;
  logic [31:0] seed, d;
  int bad_count, samples_checked, cyc, ch, p, t, v;
  string rq[6], ex[6];
  cacu_alarm_cmd dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_err_i(rx_err),
    .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .reading_i(reading), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata),
    .do_o(do_o), .scale_o(scale_o), .irq_o(irq_o));
  cacu_host_model host (.core_clk_i(core_clk_i), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_err_o(rx_err), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic string lim(input int x);
    int a;
    a = (x < 0) ? -x : x;
    return $sformatf("%s%03d.%02d", (x < 0) ? "-" : "+", a / 100, a % 100);
  endfunction
  function automatic string rq1(input logic [15:0] c, input string s);
    return $sformatf("@01%s%s", c, s);
  endfunction
  function automatic string setl(input int x, input int c, input int l,
                                 input int o);
    return rq1(`CACU_SET_LOW_LIMIT_CODE, $sformatf("%sC%0d%cO%0d", lim(x), c,
      l ? `CACU_CH_L : `CACU_CH_M, o));
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input string e, input string g);
    samples_checked++;
    if (e != g) begin
      bad_count++;
      $display("ERROR %s expected %s seen %s", n, e, g);
    end
  endtask
  task automatic chkv(input string n, input logic [31:0] e,
                      input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic cmd(input string s, input string e, input bit err = 1'b0);
    string r;
    host.send(s, err);
    host.get(r);
    chk(s, e, r);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] x);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= x;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] x);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 x = reg_rdata;
  endtask
  task automatic setr(input int c, input int x);
    @(posedge core_clk_i);
    reading[18 * c +: 18] <= x[17:0];
    repeat (4) @(posedge core_clk_i);
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 30000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    seed = 32'h0000002E;
    rst_n_i = 1'b0;
    reg_addr_i = 5'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    for (int i = 0; i < 8; i++) reading[18 * i +: 18] = 18'h1869F;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1 chkv("scale", 32'h0, scale_o);
    chkv("ports", 32'h0, do_o);
    rd(`CACU_REG_ADDR, d);
    chkv("address", 32'h01, d);
    for (int i = 0; i < 6; i++) begin
      host.slow = i >= 3;
      ch = rnd() % 8;
      p = rnd() % 8;
      t = rnd() % 2;
      v = int'(rnd() % 32'd199999) - 99999;
      cmd(setl(v, ch, t, p), "!01");
      cmd(rq1(`CACU_READ_LOW_SETTINGS_CODE, $sformatf("C%0d", ch)),
        $sformatf("!01%s%0dO%0d", lim(v), t + 1, p));
    end
    rq = '{rq1(`CACU_READ_LOW_SETTINGS_CODE, "C8"),
      rq1(`CACU_READ_ACTIVE_ALARMS_CODE, "O9"), "@01ZZ",
      $sformatf("@02%sC0", `CACU_READ_LOW_SETTINGS_CODE),
      rq1(`CACU_SET_LOW_LIMIT_CODE, "+1C0MO1"),
      rq1(`CACU_READ_LOW_SETTINGS_CODE, "C0")};
    ex = '{"?01", "?01", "?01", "", "", ""};
    for (int i = 0; i < 6; i++) cmd(rq[i], ex[i], i == 5);
    rd(`CACU_REG_STAT, d);
    chkv("status", 32'h0E, d);
    wr(`CACU_REG_STAT, 32'h0F);
    wr(`CACU_REG_MASK, 32'h02);
    #1 chkv("irq idle", 32'h0, irq_o);
    cmd(rq1(`CACU_READ_HIGH_SETTINGS_CODE, "C0"),
      "!01+000.000O0");
    chkv("irq set", 32'h1, irq_o);
    wr(`CACU_REG_MASK, 32'h01);
    @(posedge core_clk_i);
    #1 chkv("irq masked", 32'h0, irq_o);
    wr(`CACU_REG_STAT, 32'h0F);
    rd(`CACU_REG_STAT, d);
    chkv("status clear", 32'h0, d);
    rd(5'h1C, d);
    chkv("unmapped", 32'h0, d);
    for (int i = 0; i < 8; i++) cmd(setl(-99999, i, 0, 3), "!01");
    wr(`CACU_REG_DOUT, 32'hFF);
    rd(`CACU_REG_DOUT, d);
    chkv("direct out", 32'hF7, d);
    cmd(setl(-500, 2, 0, 3), "!01");
    cmd(setl(1000, 5, 1, 3), "!01");
    setr(2, -600);
    setr(5, 0);
    chkv("port on", 32'h08, do_o & 8'h08);
    chkv("irq alarm", 32'h1, irq_o);
    cmd(rq1(`CACU_READ_ACTIVE_ALARMS_CODE, "O3"),
      $sformatf("!0100%02X", 8'h24));
    setr(2, 99999);
    cmd(rq1(`CACU_READ_ACTIVE_ALARMS_CODE, "O3"), "!010020");
    chkv("port held", 32'h08, do_o & 8'h08);
    setr(5, 99999);
    cmd(rq1(`CACU_CLEAR_HIGH_LATCH_CODE, "C5"), "!01");
    cmd(rq1(`CACU_READ_ACTIVE_ALARMS_CODE, "O3"), "!010020");
    cmd(rq1(`CACU_CLEAR_LOW_LATCH_CODE, "C5"), "!01");
    cmd(rq1(`CACU_READ_ACTIVE_ALARMS_CODE, "O3"), "!010000");
    chkv("port off", 32'h0, do_o & 8'h08);
    cmd(rq1(`CACU_READ_ACTIVE_ALARMS_CODE, "O0"), "!010000");
    wr(`CACU_REG_CTRL, 32'h1);
    #1 chkv("scale other", 32'h1, scale_o);
    cmd(setl(-500, 2, 0, 3), "!01");
    wr(`CACU_REG_CTRL, 32'h0);
    cmd(rq1(`CACU_SET_HIGH_LIMIT_CODE, "+010.00C1LO4"), "!01");
    cmd(rq1(`CACU_READ_HIGH_SETTINGS_CODE, "C1A7"),
      "!01+010.002O4");
    cmd(rq1(`CACU_READ_ACTIVE_ALARMS_CODE, "O4"), "!010200");
    chkv("high port", 32'h10, do_o & 8'h10);
    report_and_stop();
  end
endmodule
